//--- hdl/ioldp_pkg.sv
// package: register map and reset values of the line drive control block
package ioldp_pkg;
    localparam int unsigned NUM_LINES = 32;
    localparam int unsigned ADDR_W = 8;
    // ********************
    // register offsets
    // ********************
    localparam logic [7:0] OFF_MULTI_DRIVE_ENABLE = 8'h00;
    localparam logic [7:0] OFF_MULTI_DRIVE_DISABLE = 8'h04;
    localparam logic [7:0] OFF_MULTI_DRIVE_STATE = 8'h08;
    localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h10;
    localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h14;
    localparam logic [7:0] OFF_PULLUP_STATE = 8'h18;
    localparam logic [7:0] OFF_FUNCTION_A_SELECT = 8'h20;
    localparam logic [7:0] OFF_FUNCTION_B_SELECT = 8'h24;
    localparam logic [7:0] OFF_FUNCTION_SELECT_STATE = 8'h28;
    localparam logic [7:0] OFF_DIRECT_WRITE_ENABLE = 8'h30;
    localparam logic [7:0] OFF_DIRECT_WRITE_DISABLE = 8'h34;
    localparam logic [7:0] OFF_DIRECT_WRITE_STATE = 8'h38;
    localparam logic [7:0] OFF_OUTPUT_VALUE = 8'h3C;
    // ********************
    // reset values and unmapped read value
    // ********************
    localparam logic [31:0] RST_MULTI_DRIVE = 32'h00000000;
    localparam logic [31:0] RST_PULLUP_OFF = 32'h00000000;
    localparam logic [31:0] RST_FUNC_B = 32'h00000000;
    localparam logic [31:0] RST_DIRECT_WRITE = 32'h00000000;
    localparam logic [31:0] RST_OUTPUT_VALUE = 32'h00000000;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
    localparam logic [31:0] RST_PIN_OE_N = 32'hFFFFFFFF;
    localparam logic [31:0] RST_PULLUP_ON = 32'hFFFFFFFF;
    localparam logic [31:0] RST_READ_DATA = 32'h00000000;
endpackage

//--- hdl/ioldp_ctrl.sv
// module: per-line drive, pull-up, function mux and write-gate control
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - a one in multi-drive disable turns open-drain off for that line
// - state zero: pin actively driven high and low
// - state one: pin driven low only, released when high
// - a one in pull-up disable switches that line's pull-up off
// - a one in pull-up enable switches that line's pull-up on
// - pull-up state reads zero when enabled, one when disabled
// - a one in function A select routes line to function A
// - a one in function B select routes line to function B
// - selection state reads zero for function A, one for B
// - a one in direct write enable lets output value writes reach line
// - a one in direct write disable blocks output value writes on line
// - direct write state zero: output value writes leave line alone
// - direct write state one: output value writes change the line
// - output value bit holds level to drive, one high, zero low
module ioldp_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n,
    output logic [31:0] pullup_on,
    output logic [31:0] func_b_sel
);

    // ********************
    // register decode
    // ********************
    logic wr_mde;
    logic wr_mdd;
    logic wr_pud;
    logic wr_pue;
    logic wr_fa;
    logic wr_fb;
    logic wr_dwe;
    logic wr_dwd;
    logic wr_ov;

    logic rd_mds;
    logic rd_pus;
    logic rd_fss;
    logic rd_dws;
    logic rd_ov;

    // one strobe per written register; status offsets decode to nothing
    always_comb begin
        wr_mde = 1'b0;
        wr_mdd = 1'b0;
        wr_pud = 1'b0;
        wr_pue = 1'b0;
        wr_fa = 1'b0;
        wr_fb = 1'b0;
        wr_dwe = 1'b0;
        wr_dwd = 1'b0;
        wr_ov = 1'b0;
        if (wr_en) begin
            case (addr)
                ioldp_pkg::OFF_MULTI_DRIVE_ENABLE: begin
                    wr_mde = 1'b1;
                end
                ioldp_pkg::OFF_MULTI_DRIVE_DISABLE: begin
                    wr_mdd = 1'b1;
                end
                ioldp_pkg::OFF_PULLUP_DISABLE: begin
                    wr_pud = 1'b1;
                end
                ioldp_pkg::OFF_PULLUP_ENABLE: begin
                    wr_pue = 1'b1;
                end
                ioldp_pkg::OFF_FUNCTION_A_SELECT: begin
                    wr_fa = 1'b1;
                end
                ioldp_pkg::OFF_FUNCTION_B_SELECT: begin
                    wr_fb = 1'b1;
                end
                ioldp_pkg::OFF_DIRECT_WRITE_ENABLE: begin
                    wr_dwe = 1'b1;
                end
                ioldp_pkg::OFF_DIRECT_WRITE_DISABLE: begin
                    wr_dwd = 1'b1;
                end
                ioldp_pkg::OFF_OUTPUT_VALUE: begin
                    wr_ov = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // write-only and unmapped offsets raise no read strobe
    always_comb begin
        rd_mds = 1'b0;
        rd_pus = 1'b0;
        rd_fss = 1'b0;
        rd_dws = 1'b0;
        rd_ov = 1'b0;
        if (rd_en) begin
            case (addr)
                ioldp_pkg::OFF_MULTI_DRIVE_STATE: begin
                    rd_mds = 1'b1;
                end
                ioldp_pkg::OFF_PULLUP_STATE: begin
                    rd_pus = 1'b1;
                end
                ioldp_pkg::OFF_FUNCTION_SELECT_STATE: begin
                    rd_fss = 1'b1;
                end
                ioldp_pkg::OFF_DIRECT_WRITE_STATE: begin
                    rd_dws = 1'b1;
                end
                ioldp_pkg::OFF_OUTPUT_VALUE: begin
                    rd_ov = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // ********************
    // per-line state and pin drive
    // ********************
    for (genvar i = 0; i < ioldp_pkg::NUM_LINES; i++) begin : g_line
        logic md_d;
        logic md_q;
        logic pu_off_d;
        logic pu_off_q;
        logic fn_b_d;
        logic fn_b_q;
        logic dw_d;
        logic dw_q;
        logic ov_d;
        logic ov_q;
        logic rd_d;
        logic rd_q;

        logic md_set;
        logic md_clr;
        logic pu_off_set;
        logic pu_off_clr;
        logic fn_b_set;
        logic fn_b_clr;
        logic dw_set;
        logic dw_clr;
        logic ov_load;

        logic out_d;
        logic out_q;
        logic oe_n_d;
        logic oe_n_q;
        logic pu_on_d;
        logic pu_on_q;
        logic fn_sel_d;
        logic fn_sel_q;

        // ********************
        // per-line write strobes
        // ********************
        assign md_set = wr_mde & wdata[i];
        assign md_clr = wr_mdd & wdata[i];
        assign pu_off_set = wr_pud & wdata[i];
        assign pu_off_clr = wr_pue & wdata[i];
        assign fn_b_set = wr_fb & wdata[i];
        assign fn_b_clr = wr_fa & wdata[i];
        assign dw_set = wr_dwe & wdata[i];
        assign dw_clr = wr_dwd & wdata[i];
        assign ov_load = wr_ov & dw_q;

        // ********************
        // multi-drive
        // ********************
        // enable and disable sit at separate offsets, so one write
        // sets or clears a line but never both
        always_comb begin
            md_d = md_q;
            if (md_set) begin
                md_d = 1'b1;
            end else if (md_clr) begin
                md_d = 1'b0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                md_q <= ioldp_pkg::RST_MULTI_DRIVE[i];
            end else begin
                md_q <= md_d;
            end
        end

        // ********************
        // pull-up
        // ********************
        // state holds one while the resistor is off
        always_comb begin
            pu_off_d = pu_off_q;
            if (pu_off_set) begin
                pu_off_d = 1'b1;
            end else if (pu_off_clr) begin
                pu_off_d = 1'b0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pu_off_q <= ioldp_pkg::RST_PULLUP_OFF[i];
            end else begin
                pu_off_q <= pu_off_d;
            end
        end

        // ********************
        // function select
        // ********************
        // state holds one while the line is routed to function B
        always_comb begin
            fn_b_d = fn_b_q;
            if (fn_b_set) begin
                fn_b_d = 1'b1;
            end else if (fn_b_clr) begin
                fn_b_d = 1'b0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                fn_b_q <= ioldp_pkg::RST_FUNC_B[i];
            end else begin
                fn_b_q <= fn_b_d;
            end
        end

        // ********************
        // direct write gate
        // ********************
        always_comb begin
            dw_d = dw_q;
            if (dw_set) begin
                dw_d = 1'b1;
            end else if (dw_clr) begin
                dw_d = 1'b0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                dw_q <= ioldp_pkg::RST_DIRECT_WRITE[i];
            end else begin
                dw_q <= dw_d;
            end
        end

        // ********************
        // output value
        // ********************
        // a value write lands only where direct write is allowed
        always_comb begin
            ov_d = ov_q;
            if (ov_load) begin
                ov_d = wdata[i];
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                ov_q <= ioldp_pkg::RST_OUTPUT_VALUE[i];
            end else begin
                ov_q <= ov_d;
            end
        end

        // ********************
        // pin drive
        // ********************
        // an open-drain line lets go of the pin instead of driving high
        always_comb begin
            case ({md_q, ov_q})
                2'b11: begin
                    oe_n_d = 1'b1;
                end
                2'b10: begin
                    oe_n_d = 1'b0;
                end
                default: begin
                    oe_n_d = 1'b0;
                end
            endcase
        end

        assign out_d = ov_q;
        assign pu_on_d = ~pu_off_q;
        assign fn_sel_d = fn_b_q;

        // pin outputs follow the state one edge later
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                out_q <= ioldp_pkg::RST_OUTPUT_VALUE[i];
            end else begin
                out_q <= out_d;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                oe_n_q <= ioldp_pkg::RST_PIN_OE_N[i];
            end else begin
                oe_n_q <= oe_n_d;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pu_on_q <= ioldp_pkg::RST_PULLUP_ON[i];
            end else begin
                pu_on_q <= pu_on_d;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                fn_sel_q <= ioldp_pkg::RST_FUNC_B[i];
            end else begin
                fn_sel_q <= fn_sel_d;
            end
        end

        // ********************
        // read back
        // ********************
        // strobes never overlap, so the order of the checks is free
        always_comb begin
            rd_d = 1'b0;
            if (rd_mds) begin
                rd_d = md_q;
            end else if (rd_pus) begin
                rd_d = pu_off_q;
            end else if (rd_fss) begin
                rd_d = fn_b_q;
            end else if (rd_dws) begin
                rd_d = dw_q;
            end else if (rd_ov) begin
                rd_d = ov_q;
            end else if (rd_en) begin
                rd_d = ioldp_pkg::RD_UNMAPPED[i];
            end
        end

        // read data stands one cycle, then falls back to zero
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                rd_q <= ioldp_pkg::RST_READ_DATA[i];
            end else begin
                rd_q <= rd_d;
            end
        end

        assign pin_out[i] = out_q;
        assign pin_oe_n[i] = oe_n_q;
        assign pullup_on[i] = pu_on_q;
        assign func_b_sel[i] = fn_sel_q;
        assign rdata[i] = rd_q;
    end

endmodule

`default_nettype wire

//--- verif/ioldp_ctrl_sva.sv
// checker: port relations of the line drive control block
`timescale 1ns/1ps
`default_nettype none
module ioldp_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] pullup_on,
    input wire logic [31:0] func_b_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h00000000)
        else $error("read data outside slot");
    pu_on_a: assert property (wr_en && addr == 8'h14 ##1 !wr_en |=>
        (~pullup_on & $past(wdata, 2)) == 0) else $error("pull-up not on");
    pu_off_a: assert property (wr_en && addr == 8'h10 ##1 !wr_en |=>
        (pullup_on & $past(wdata, 2)) == 0) else $error("pull-up not off");
    fn_b_a: assert property (wr_en && addr == 8'h24 ##1 !wr_en |=>
        (~func_b_sel & $past(wdata, 2)) == 0) else $error("not on B");
    fn_a_a: assert property (wr_en && addr == 8'h20 ##1 !wr_en |=>
        (func_b_sel & $past(wdata, 2)) == 0) else $error("not on A");
    md_off_a: assert property (wr_en && addr == 8'h04 ##1 !wr_en |=>
        (pin_oe_n & $past(wdata, 2)) == 0) else $error("still released");
    oe_rel_a: assert property (!$past(rst) |->
        (pin_oe_n & ~pin_out) == 0) else $error("released while low");
    pu_st_a: assert property (rd_en && addr == 8'h18 |=>
        rdata == ~pullup_on) else $error("pull-up state mismatch");
endmodule
bind ioldp_ctrl ioldp_chk i_chk (.clk, .rst, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .pin_out, .pin_oe_n, .pullup_on, .func_b_sel);
`default_nettype wire

//--- verif/io_line_drive_pullup_mux_ctrl_tb_top.sv
// testbench: random register traffic checked against a bit model
`timescale 1ns/1ps
`default_nettype none
module io_line_drive_pullup_mux_ctrl_tb_top;
    logic clk = 0, rst = 1, wr_en = 0, rd_en = 0;
    logic [7:0] addr = 0, a;
    logic [31:0] wdata = 0, sd = 32'h1B58, d;
    logic [31:0] rdata, pin_out, pin_oe_n, pullup_on, func_b_sel;
    logic [31:0] st [16] = '{default: 32'h0};
    int err_total = 0, checked = 0, cyc = 0;
    ioldp_ctrl i_dut (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .pin_out, .pin_oe_n, .pullup_on, .func_b_sel);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 500; i++) begin
            sd = lfsr(sd);
            d = lfsr(~sd);
            a = {2'b00, sd[7:4], 2'b00};
            addr <= a;
            wdata <= d;
            wr_en <= 1'b1;
            @(posedge clk);
            wr_en <= 1'b0;
            case (a)
                8'h00: st[2] |= d;
                8'h04: st[2] &= ~d;
                8'h10: st[6] |= d;
                8'h14: st[6] &= ~d;
                8'h20: st[10] &= ~d;
                8'h24: st[10] |= d;
                8'h30: st[14] |= d;
                8'h34: st[14] &= ~d;
                8'h3C: st[15] = st[15] & ~st[14] | d & st[14];
                default: ;
            endcase
            a = {2'b00, sd[11:8], 2'b00};
            addr <= a;
            rd_en <= 1'b1;
            @(posedge clk);
            rd_en <= 1'b0;
            #1;
            chk(rdata, st[a[5:2]]);
            chk(pin_out, st[15]);
            chk(pin_oe_n, st[2] & st[15]);
            chk(pullup_on, ~st[6]);
            chk(func_b_sel, st[10]);
            @(posedge clk);
        end
        conclude();
    end
endmodule
`default_nettype wire
